//--- vic_core_model.sv
// Purpose: behavioural processor core facing the controller
// Assumes: fetch every other cycle, handler length fixed
// Notes: hold_i keeps handlers in service so nesting can be seen
module vic_core_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic req_i,
  input wire logic [15:0] vec_i,
  input wire logic hold_i,
  input wire logic [31:0] ack_dly_i,
  output logic fetch_o,
  output logic ack_o,
  output logic ret_o,
  output logic [15:0] got_vec_o,
  output int n_got_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int depth;
  int wait_cnt;
  int ret_cnt;
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      fetch_o <= 1'b0;
      ack_o <= 1'b0;
      ret_o <= 1'b0;
      got_vec_o <= 16'h0000;
      n_got_o <= 0;
      depth <= 0;
      wait_cnt <= 0;
      ret_cnt <= 0;
    end else begin
      fetch_o <= ~fetch_o;
      ack_o <= 1'b0;
      ret_o <= 1'b0;
      // one-cycle ack, only while a request stands, optionally late
      if (req_i && !ack_o) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt >= ack_dly_i) begin
          ack_o <= 1'b1;
          got_vec_o <= vec_i;
          n_got_o <= n_got_o + 1;
          depth <= depth + 1;
          wait_cnt <= 0;
          ret_cnt <= 0;
        end
      end else if (depth > 0 && !hold_i && !req_i) begin
        ret_cnt <= ret_cnt + 1;
        if (ret_cnt >= 12) begin
          ret_o <= 1'b1;
          depth <= depth - 1;
          ret_cnt <= 0;
        end
      end
    end
  end
endmodule // vic_core_model

//--- vic_defs.vh
// Purpose: constants for the vectored interrupt controller
// Assumes: 8-bit register port, registers at the offsets below
// Notes: vector addresses are 16-bit code addresses
`ifndef VIC_DEFS_VH
`define VIC_DEFS_VH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define VIC_ADDR_W 8
`define VIC_OFS_ENABLE_MASK 8'hA8
`define VIC_OFS_LEVEL_SEL 8'hB8
`define VIC_OFS_TIMER_CTRL 8'h88
`define VIC_OFS_POWER_CTRL 8'h87
`define VIC_OFS_EXTRA_EN 8'h8F
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VIC_EN_GATE 7
`define VIC_EN_LOWSUP 6
`define VIC_EN_TB 3
`define VIC_EN_PB 2
`define VIC_EN_TA 1
`define VIC_EN_PA 0
`define VIC_LV_LOWSUP 6
`define VIC_LV_TB 3
`define VIC_LV_PB 2
`define VIC_LV_TA 1
`define VIC_LV_PA 0
`define VIC_TC_TB_FLAG 7
`define VIC_TC_TA_FLAG 5
`define VIC_TC_PB_FLAG 3
`define VIC_TC_PB_TRIG 2
`define VIC_TC_PA_FLAG 1
`define VIC_TC_PA_TRIG 0
`define VIC_PC_LOWSUP_FLAG 5
`define VIC_XE_PE 6
`define VIC_XE_PD 5
`define VIC_XE_PC 4
// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define VIC_RST_BYTE 8'h00
`define VIC_MASK_ENABLE 8'hCF
`define VIC_MASK_LEVEL 8'h4F
`define VIC_MASK_POWER 8'h20
`define VIC_MASK_EXTRA 8'h70
// ----------------------------------------------------------------
// sources in polling order, rank and vector
// ----------------------------------------------------------------
`define VIC_NSRC 8
`define VIC_SRC_W 3
`define VIC_RANK_W 5
`define VIC_VEC_W 16
`define VIC_VEC_PA 16'h0003
`define VIC_VEC_TA 16'h000B
`define VIC_VEC_PB 16'h0013
`define VIC_VEC_TB 16'h001B
`define VIC_VEC_LS 16'h0033
`define VIC_VEC_PC 16'h0053
`define VIC_VEC_PD 16'h005B
`define VIC_VEC_PE 16'h0083
`define VIC_RANK_PA 5'h00
`define VIC_RANK_TA 5'h01
`define VIC_RANK_PB 5'h02
`define VIC_RANK_TB 5'h03
`define VIC_RANK_LS 5'h06
`define VIC_RANK_PC 5'h0A
`define VIC_RANK_PD 5'h0B
`define VIC_RANK_PE 5'h10
`endif

//--- vic_sync.v
// Purpose: two-flop synchroniser for the external request pins
// Assumes: pins are asynchronous to the core clock
// Notes: first stage feeds only the second stage
module vic_sync #(
  parameter W = 5
) (
  input wire CORE_CLK_I,
  input wire RST_B_I,
  input wire CE_I,
  input wire [W-1:0] PIN_I,
  output reg [W-1:0] SYNC_O
);
  reg [W-1:0] meta_reg;

  always @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      meta_reg <= {W{1'b1}};
      SYNC_O <= {W{1'b1}};
    end else if (CE_I) begin
      meta_reg <= PIN_I;
      SYNC_O <= meta_reg;
    end
  end
endmodule // vic_sync

//--- vic_top.v
// Purpose: vectored interrupt controller of a small 8-bit core
// Assumes: core gives fetch and return strobes, one-cycle acknowledge
// Notes: timer and supply detector live outside; only their events enter
//
// Operation
// - pin a: vector 0003, rank 0
// - timer a 000B, pin b 0013, timer b 001B
// - low supply 0033; pins c,d 0053, 005B
// - pin e: vector 0083, rank 16, lowest
// - per-source enable and global gate block requests
// - level bit for five sources, pins c-e low
// - low level never preempts high-level handler
// - higher level wins among simultaneous requests
// - same level: smallest polling rank wins
// - pins a,b: falling edge or both edges
// - pin a/b flag cleared on acknowledge
// - any pin request raises interrupt and wakes core
// - timer flag set on rollover, cleared on vector
// - low supply flag is bit 5, software clears
// - detector input sets low supply flag
// - pins c-e: falling edge only
// - hidden pins c-e flag, cleared by ack/disable
// - software set/clear equals hardware set/clear
// - sample at fetch, evaluate at next fetch
// - return releases current level's in-service state
// - after return, one instruction before next vector
`include "vic_defs.vh"
module vic_top (
  input wire CORE_CLK_I,
  input wire RST_B_I,
  input wire CE_I,
  input wire [`VIC_ADDR_W-1:0] REG_ADDR_I,
  input wire [7:0] REG_WDATA_I,
  input wire REG_WR_I,
  input wire REG_RD_I,
  output reg [7:0] REG_RDATA_O,
  input wire [4:0] IRQ_PIN_I,
  input wire TIMER_A_ROLL_I,
  input wire TIMER_B_ROLL_I,
  input wire LOW_SUPPLY_DET_I,
  input wire FETCH_I,
  input wire RETURN_I,
  input wire ACK_I,
  output wire IRQ_REQ_O,
  output reg [`VIC_VEC_W-1:0] IRQ_VEC_O,
  output reg WAKE_O
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [4:0] pin_sync;
  reg [4:0] pin_prev_reg;

  // pins idle high and reset to high, so no false fall follows reset
  vic_sync #(.W(5)) u_sync (
    .CORE_CLK_I(CORE_CLK_I),
    .RST_B_I(RST_B_I),
    .CE_I(CE_I),
    .PIN_I(IRQ_PIN_I),
    .SYNC_O(pin_sync)
  );

  wire [4:0] fall = pin_prev_reg & ~pin_sync;
  wire [4:0] rise = ~pin_prev_reg & pin_sync;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg [7:0] enable_mask_reg;
  reg [7:0] level_select_reg;
  reg pin_a_trigger_select_reg;
  reg pin_b_trigger_select_reg;
  reg [7:0] extra_enable_reg;
  reg pin_a_flag_reg;
  reg pin_b_flag_reg;
  reg timer_a_overflow_flag_reg;
  reg timer_b_overflow_flag_reg;
  reg low_supply_flag_reg;
  wire [2:0] hidden_flag;

  // a write beside a read is dropped; a sound master never issues both
  wire wr_en = CE_I & REG_WR_I & ~REG_RD_I;
  wire wr_enable = wr_en & (REG_ADDR_I == `VIC_OFS_ENABLE_MASK);
  wire wr_level = wr_en & (REG_ADDR_I == `VIC_OFS_LEVEL_SEL);
  wire wr_timer = wr_en & (REG_ADDR_I == `VIC_OFS_TIMER_CTRL);
  wire wr_power = wr_en & (REG_ADDR_I == `VIC_OFS_POWER_CTRL);
  wire wr_extra = wr_en & (REG_ADDR_I == `VIC_OFS_EXTRA_EN);

  wire global_irq_gate = enable_mask_reg[`VIC_EN_GATE];
  wire pin_irq_c_enable = extra_enable_reg[`VIC_XE_PC];
  wire pin_irq_d_enable = extra_enable_reg[`VIC_XE_PD];
  wire pin_irq_e_enable = extra_enable_reg[`VIC_XE_PE];

  // ----------------------------------------------------------------
  // source vectors in polling order: pa, ta, pb, tb, ls, pc, pd, pe
  // ----------------------------------------------------------------
  wire [`VIC_NSRC-1:0] src_flag = {hidden_flag, low_supply_flag_reg,
    timer_b_overflow_flag_reg, pin_b_flag_reg, timer_a_overflow_flag_reg,
    pin_a_flag_reg};
  wire [`VIC_NSRC-1:0] src_en = {pin_irq_e_enable, pin_irq_d_enable,
    pin_irq_c_enable, enable_mask_reg[`VIC_EN_LOWSUP],
    enable_mask_reg[`VIC_EN_TB], enable_mask_reg[`VIC_EN_PB],
    enable_mask_reg[`VIC_EN_TA], enable_mask_reg[`VIC_EN_PA]};
  wire [`VIC_NSRC-1:0] src_high = {3'b000,
    level_select_reg[`VIC_LV_LOWSUP], level_select_reg[`VIC_LV_TB],
    level_select_reg[`VIC_LV_PB], level_select_reg[`VIC_LV_TA],
    level_select_reg[`VIC_LV_PA]};

  // index to vector; index order already follows rank order
  // vectors are fixed by the source slot; software cannot move them
  function [`VIC_VEC_W-1:0] vec_of;
    input [`VIC_SRC_W-1:0] idx;
    begin
      case (idx)
        3'h0: vec_of = `VIC_VEC_PA;
        3'h1: vec_of = `VIC_VEC_TA;
        3'h2: vec_of = `VIC_VEC_PB;
        3'h3: vec_of = `VIC_VEC_TB;
        3'h4: vec_of = `VIC_VEC_LS;
        3'h5: vec_of = `VIC_VEC_PC;
        3'h6: vec_of = `VIC_VEC_PD;
        default: vec_of = `VIC_VEC_PE;
      endcase
    end
  endfunction

  // lowest set index, i.e. smallest polling rank
  // the loop runs downwards so the lowest set index is written last
  function [`VIC_SRC_W:0] first_set;
    input [`VIC_NSRC-1:0] v;
    integer k;
    begin
      first_set = {1'b0, {`VIC_SRC_W{1'b0}}};
      for (k = `VIC_NSRC - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_set = {1'b1, k[`VIC_SRC_W-1:0]};
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // sampling and arbitration
  // ----------------------------------------------------------------
  reg [`VIC_NSRC-1:0] sample_reg;
  // two bits suffice: only a high handler can nest on a low one
  reg [1:0] in_service_reg; // bit1 high level, bit0 low level
  reg hold_reg; // one-instruction hold after a return
  reg req_reg;
  reg [`VIC_SRC_W-1:0] src_reg;

  wire [`VIC_NSRC-1:0] live = sample_reg & src_en & src_flag
    & {`VIC_NSRC{global_irq_gate}};
  wire [`VIC_SRC_W:0] hi_pick = first_set(live & src_high);
  wire [`VIC_SRC_W:0] lo_pick = first_set(live & ~src_high);
  // high level blocked only by a high handler; low by any handler
  wire hi_ok = hi_pick[`VIC_SRC_W] & ~in_service_reg[1];
  wire lo_ok = lo_pick[`VIC_SRC_W] & ~in_service_reg[1]
    & ~in_service_reg[0];
  wire [`VIC_SRC_W-1:0] win = hi_ok ? hi_pick[`VIC_SRC_W-1:0]
    : lo_pick[`VIC_SRC_W-1:0];
  // one request stands at a time; the next waits for the ack
  wire grant = FETCH_I & ~hold_reg & ~req_reg & (hi_ok | lo_ok);

  assign IRQ_REQ_O = req_reg;

  // ack counts only while a request stands; a stray pulse is ignored
  wire ack_take = ACK_I & req_reg;
  wire ack = CE_I & ack_take;
  wire [`VIC_NSRC-1:0] ack_hit = {`VIC_NSRC{ack}} & (8'h01 << src_reg);

  always @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      sample_reg <= 8'h00;
      in_service_reg <= 2'b00;
      hold_reg <= 1'b0;
      req_reg <= 1'b0;
      src_reg <= 3'h0;
      IRQ_VEC_O <= 16'h0000;
    end else if (CE_I) begin
      if (FETCH_I) begin
        sample_reg <= src_flag;
      end
      // the fetch that clears the hold cannot grant, so one instruction runs
      if (RETURN_I) begin
        hold_reg <= 1'b1;
      end else if (FETCH_I) begin
        hold_reg <= 1'b0;
      end
      if (grant) begin
        req_reg <= 1'b1;
        src_reg <= win;
        IRQ_VEC_O <= vec_of(win);
      end else if (ack_take) begin
        req_reg <= 1'b0;
      end
      if (ack_take) begin
        if (src_high[src_reg]) begin
          in_service_reg[1] <= 1'b1;
        end else begin
          in_service_reg[0] <= 1'b1;
        end
      end else if (RETURN_I) begin
        // release the level most recently entered
        if (in_service_reg[1]) begin
          in_service_reg[1] <= 1'b0;
        end else begin
          in_service_reg[0] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // request flags; hardware set wins over any clear
  // ----------------------------------------------------------------
  // trigger select 1 takes falls only; 0 takes both edges
  wire pa_edge = fall[0] | (~pin_a_trigger_select_reg & rise[0]);
  wire pb_edge = fall[1] | (~pin_b_trigger_select_reg & rise[1]);
  wire [2:0] cde_edge = fall[4:2];
  wire [2:0] cde_en = {pin_irq_e_enable, pin_irq_d_enable, pin_irq_c_enable};

  always @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      pin_prev_reg <= 5'h1F;
      enable_mask_reg <= `VIC_RST_BYTE;
      level_select_reg <= `VIC_RST_BYTE;
      extra_enable_reg <= `VIC_RST_BYTE;
      pin_a_trigger_select_reg <= 1'b0;
      pin_b_trigger_select_reg <= 1'b0;
      pin_a_flag_reg <= 1'b0;
      pin_b_flag_reg <= 1'b0;
      timer_a_overflow_flag_reg <= 1'b0;
      timer_b_overflow_flag_reg <= 1'b0;
      low_supply_flag_reg <= 1'b0;
      WAKE_O <= 1'b0;
    end else if (CE_I) begin
      pin_prev_reg <= pin_sync;
      WAKE_O <= pa_edge | pb_edge | (|cde_edge);
      if (wr_enable) begin
        enable_mask_reg <= REG_WDATA_I & `VIC_MASK_ENABLE;
      end
      if (wr_level) begin
        level_select_reg <= REG_WDATA_I & `VIC_MASK_LEVEL;
      end
      if (wr_extra) begin
        extra_enable_reg <= REG_WDATA_I & `VIC_MASK_EXTRA;
      end
      if (wr_timer) begin
        pin_a_trigger_select_reg <= REG_WDATA_I[`VIC_TC_PA_TRIG];
        pin_b_trigger_select_reg <= REG_WDATA_I[`VIC_TC_PB_TRIG];
      end
      // pin a
      if (pa_edge) begin
        pin_a_flag_reg <= 1'b1;
      end else if (wr_timer) begin
        pin_a_flag_reg <= REG_WDATA_I[`VIC_TC_PA_FLAG];
      end else if (ack_hit[0]) begin
        pin_a_flag_reg <= 1'b0;
      end
      // pin b
      if (pb_edge) begin
        pin_b_flag_reg <= 1'b1;
      end else if (wr_timer) begin
        pin_b_flag_reg <= REG_WDATA_I[`VIC_TC_PB_FLAG];
      end else if (ack_hit[2]) begin
        pin_b_flag_reg <= 1'b0;
      end
      // timers
      // a rollover in the ack cycle wins, so no overflow is lost
      if (TIMER_A_ROLL_I) begin
        timer_a_overflow_flag_reg <= 1'b1;
      end else if (wr_timer) begin
        timer_a_overflow_flag_reg <= REG_WDATA_I[`VIC_TC_TA_FLAG];
      end else if (ack_hit[1]) begin
        timer_a_overflow_flag_reg <= 1'b0;
      end
      if (TIMER_B_ROLL_I) begin
        timer_b_overflow_flag_reg <= 1'b1;
      end else if (wr_timer) begin
        timer_b_overflow_flag_reg <= REG_WDATA_I[`VIC_TC_TB_FLAG];
      end else if (ack_hit[3]) begin
        timer_b_overflow_flag_reg <= 1'b0;
      end
      // low supply: no clear on acknowledge
      if (LOW_SUPPLY_DET_I) begin
        low_supply_flag_reg <= 1'b1;
      end else if (wr_power) begin
        low_supply_flag_reg <= REG_WDATA_I[`VIC_PC_LOWSUP_FLAG];
      end
    end
  end

  // ----------------------------------------------------------------
  // hidden pin c-e flags; disable holds them clear
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_hidden
      reg flag_reg;
      always @(posedge CORE_CLK_I) begin
        if (!RST_B_I) begin
          flag_reg <= 1'b0;
        end else if (CE_I) begin
          if (!cde_en[g]) begin
            flag_reg <= 1'b0;
          end else if (cde_edge[g]) begin
            flag_reg <= 1'b1;
          end else if (ack_hit[5+g]) begin
            flag_reg <= 1'b0;
          end
        end
      end
      assign hidden_flag[g] = flag_reg;
    end
  endgenerate

  // ----------------------------------------------------------------
  // read port; hidden flags are never visible
  // ----------------------------------------------------------------
  always @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (CE_I) begin
      // idle data reads zero so a stale byte never looks like a read
      if (!REG_RD_I) begin
        REG_RDATA_O <= 8'h00;
      end else if (REG_ADDR_I == `VIC_OFS_ENABLE_MASK) begin
        REG_RDATA_O <= enable_mask_reg;
      end else if (REG_ADDR_I == `VIC_OFS_LEVEL_SEL) begin
        REG_RDATA_O <= level_select_reg;
      end else if (REG_ADDR_I == `VIC_OFS_TIMER_CTRL) begin
        REG_RDATA_O <= {timer_b_overflow_flag_reg, 1'b0, timer_a_overflow_flag_reg,
          1'b0, pin_b_flag_reg, pin_b_trigger_select_reg, pin_a_flag_reg,
          pin_a_trigger_select_reg};
      end else if (REG_ADDR_I == `VIC_OFS_POWER_CTRL) begin
        REG_RDATA_O <= {2'b00, low_supply_flag_reg, 5'h00};
      end else if (REG_ADDR_I == `VIC_OFS_EXTRA_EN) begin
        REG_RDATA_O <= extra_enable_reg;
      end else begin
        REG_RDATA_O <= 8'h00;
      end
    end
  end
endmodule // vic_top

//--- vic_top_checker.sv
// Purpose: port-level checks of the interrupt controller
// Assumes: one clock domain, synchronous active-low reset, CE_I held high
// Notes: attached by bind at the foot of this file
`include "vic_defs.vh"
module vic_top_checker (
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  input wire logic [`VIC_ADDR_W-1:0] REG_ADDR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic [4:0] IRQ_PIN_I,
  input wire logic FETCH_I,
  input wire logic ACK_I,
  input wire logic IRQ_REQ_O,
  input wire logic [`VIC_VEC_W-1:0] IRQ_VEC_O,
  input wire logic WAKE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // ----------------------------------------------------------------
  // core link
  // ----------------------------------------------------------------
  property p_vec_known;
    IRQ_REQ_O |-> IRQ_VEC_O inside {`VIC_VEC_PA, `VIC_VEC_TA, `VIC_VEC_PB, `VIC_VEC_TB,
      `VIC_VEC_LS, `VIC_VEC_PC, `VIC_VEC_PD, `VIC_VEC_PE};
  endproperty
  a_vec_known: assert property (p_vec_known) else $error("vector off table");
  property p_req_holds;
    IRQ_REQ_O && !ACK_I |=> IRQ_REQ_O;
  endproperty
  a_req_holds: assert property (p_req_holds) else $error("request dropped early");
  property p_req_drop;
    IRQ_REQ_O && ACK_I |=> !IRQ_REQ_O;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
  property p_vec_stable;
    IRQ_REQ_O && $past(IRQ_REQ_O) |-> IRQ_VEC_O == $past(IRQ_VEC_O);
  endproperty
  a_vec_stable: assert property (p_vec_stable) else $error("vector moved");
  property p_rise_fetch;
    $rose(IRQ_REQ_O) |-> $past(FETCH_I);
  endproperty
  a_rise_fetch: assert property (p_rise_fetch) else $error("grant off fetch");
  property p_wake;
    $fell(IRQ_PIN_I[2]) || $fell(IRQ_PIN_I[3]) || $fell(IRQ_PIN_I[4]) |-> ##[1:6] WAKE_O;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on pin fall");
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  property p_rdata_idle;
    !$past(REG_RD_I) |-> REG_RDATA_O == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_rsvd;
    $past(REG_RD_I) && $past(REG_ADDR_I) == `VIC_OFS_LEVEL_SEL |->
      (REG_RDATA_O & ~`VIC_MASK_LEVEL) == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("level bits for fixed pins");
  cover property ($rose(IRQ_REQ_O));
  cover property (IRQ_REQ_O && ACK_I);
  cover property (WAKE_O);
endmodule // vic_top_checker
bind vic_top vic_top_checker u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .IRQ_PIN_I(IRQ_PIN_I), .FETCH_I(FETCH_I), .ACK_I(ACK_I), .IRQ_REQ_O(IRQ_REQ_O),
  .IRQ_VEC_O(IRQ_VEC_O), .WAKE_O(WAKE_O));

//--- vic_top_tb.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: core model acks and returns; bench plays software
// Notes: flags are set by pins, timer or detector pulses, or register writes
`include "vic_defs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module vic_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [4:0] pins = 5'h1F;
  logic roll_a = 1'b0;
  logic roll_b = 1'b0;
  logic low_det = 1'b0;
  logic hold = 1'b0;
  int ack_dly = 0;
  wire [7:0] rdata;
  wire fetch, ack, ret, req, wake;
  wire [15:0] vec, got_vec;
  int n_got, seen, n_mismatch, n_checks, cyc;
  logic [7:0] en_tab [8] = '{8'h81, 8'h82, 8'h84, 8'h88, 8'hC0, 8'h80, 8'h80, 8'h80};
  logic [7:0] xe_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h20, 8'h40};
  logic [15:0] vec_tab [8] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0033, 16'h0053,
    16'h005B, 16'h0083};
  always #2.5 clk = ~clk;
  vic_top u_dut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .IRQ_PIN_I(pins), .TIMER_A_ROLL_I(roll_a), .TIMER_B_ROLL_I(roll_b),
    .LOW_SUPPLY_DET_I(low_det), .FETCH_I(fetch), .RETURN_I(ret), .ACK_I(ack),
    .IRQ_REQ_O(req), .IRQ_VEC_O(vec), .WAKE_O(wake));
  vic_core_model u_core (.clk_i(clk), .rst_b_i(rst_b), .req_i(req), .vec_i(vec),
    .hold_i(hold), .ack_dly_i(ack_dly), .fetch_o(fetch), .ack_o(ack), .ret_o(ret),
    .got_vec_o(got_vec), .n_got_o(n_got));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic expv(input logic [15:0] e);
    int k;
    k = 0;
    while (n_got <= seen && k < 300) begin
      @(posedge clk);
      #1;
      k++;
    end
    seen = n_got;
    `CHK(got_vec, e)
  endtask
  task automatic none();
    repeat (40) @(posedge clk);
    #1;
    `CHK(n_got, seen)
  endtask
  task automatic fire(input int i);
    @(posedge clk);
    case (i)
      0: pins[0] <= 1'b0;
      1: roll_a <= 1'b1;
      2: pins[1] <= 1'b0;
      3: roll_b <= 1'b1;
      4: low_det <= 1'b1;
      default: pins[i-3] <= 1'b0;
    endcase
    @(posedge clk);
    roll_a <= 1'b0;
    roll_b <= 1'b0;
    low_det <= 1'b0;
  endtask
  task automatic pin_a(input logic v);
    @(posedge clk);
    pins[0] <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    foreach (en_tab[i]) rdc(i < 4 ? 8'hA8 + 8'h10 * i[7:0] : 8'h00, 8'h00);
    wrr(8'hB8, 8'hFF);
    rdc(8'hB8, 8'h4F);
    wrr(8'h87, 8'hFF);
    rdc(8'h87, 8'h20);
    wrr(8'h8F, 8'hFF);
    rdc(8'h8F, 8'h70);
    wrr(8'hB8, 8'h00);
    wrr(8'h87, 8'h00);
    wrr(8'h8F, 8'h00);
    wrr(8'hA8, 8'hFF);
    rdc(8'hA8, 8'hCF);
    wrr(8'hA8, 8'h00);
    $display("test registers done");
    wrr(8'h88, 8'h05);
    for (int i = 0; i < 8; i++) begin
      ack_dly <= i % 3;
      wrr(8'h8F, xe_tab[i]);
      wrr(8'hA8, en_tab[i]);
      fire(i);
      expv(vec_tab[i]);
      wrr(8'hA8, 8'h00);
      rdc(8'h87, i == 4 ? 8'h20 : 8'h00);
      wrr(8'h87, 8'h00);
      pins <= 5'h1F;
      rdc(8'h88, 8'h05);
      repeat (30) @(posedge clk);
    end
    $display("test vectors done");
    pin_a(1'b0);
    wrr(8'h88, 8'h05);
    pin_a(1'b1);
    rdc(8'h88, 8'h05);
    wrr(8'h88, 8'h04);
    pin_a(1'b0);
    rdc(8'h88, 8'h06);
    wrr(8'h88, 8'h04);
    pin_a(1'b1);
    rdc(8'h88, 8'h06);
    wrr(8'h88, 8'h05);
    $display("test edges done");
    wrr(8'hA8, 8'h02);
    wrr(8'h88, 8'h25);
    none();
    wrr(8'hA8, 8'h82);
    expv(16'h000B);
    wrr(8'hA8, 8'h80);
    wrr(8'h88, 8'h25);
    none();
    wrr(8'h88, 8'h05);
    wrr(8'hA8, 8'h82);
    none();
    $display("test gating done");
    wrr(8'hA8, 8'h00);
    wrr(8'hB8, 8'h02);
    wrr(8'h88, 8'h27);
    wrr(8'hA8, 8'h83);
    expv(16'h000B);
    expv(16'h0003);
    wrr(8'hA8, 8'h00);
    wrr(8'hB8, 8'h00);
    wrr(8'h88, 8'h2D);
    wrr(8'hA8, 8'h87);
    expv(16'h000B);
    expv(16'h0013);
    $display("test priority done");
    repeat (30) @(posedge clk);
    hold <= 1'b1;
    ack_dly <= 3;
    wrr(8'hB8, 8'h02);
    wrr(8'h88, 8'h07);
    expv(16'h0003);
    wrr(8'h88, 8'h25);
    expv(16'h000B);
    wrr(8'h88, 8'h0D);
    none();
    hold <= 1'b0;
    expv(16'h0013);
    $display("test nesting done");
    wrr(8'hA8, 8'h00);
    wrr(8'h8F, 8'h10);
    fire(5);
    repeat (10) @(posedge clk);
    wrr(8'h8F, 8'h00);
    pins <= 5'h1F;
    wrr(8'h8F, 8'h10);
    wrr(8'hA8, 8'h80);
    none();
    $display("test hidden done");
    results();
  end
endmodule // vic_top_tb
